// [rxsc_ctrl_word.sv]
`timescale 1ns/1ps
`include "rxsc_cfg.svh"
module rxsc_ctrl_word
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        soft_reset,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_tr,
    input  wire logic [4:0]  cmd_rt_addr,
    input  wire logic [4:0]  cmd_subaddr,
    input  wire logic        msg_done,
    input  wire logic        msg_error,
    input  wire logic        index_zero_evt,
    input  wire logic        circ_count_evt,
    output logic             sel_valid,
    output logic             subaddr_busy_force,
    output logic             store_enable,
    output logic             pingpong_select_flag,
    output logic             message_irq_out
);
    logic [15:0] word_reg [0:`RXSC_NUM_SA-1];
    logic [2:0]  cfg_reg;
    logic [2:0]  gie_reg;
    logic [2:0]  stat_reg;
    logic [2:0]  stat_next;
    logic [2:0]  mask_reg;
    logic [15:0] log_reg;
    logic [4:0]  cur_sa_reg;
    logic        cur_bc_reg;
    logic        act_reg;
    rxsc_pkg::rxsc_state_e state_reg;
    logic        acc_w;
    logic        acc_r;
    logic        is_word;
    logic [4:0]  word_idx;
    logic        bc_cmd;
    logic        sel_now;
    logic        fin;
    logic [2:0]  irq_evt;
    logic [15:0] cur_word;
    logic        terminal_execute_en;
    logic        broadcast_invalid_cfg;

    assign terminal_execute_en   = cfg_reg[`RXSC_CFG_TERMINAL_EXECUTE_EN];
    assign broadcast_invalid_cfg = cfg_reg[`RXSC_CFG_BCINV];
    assign acc_w    = psel & penable & pwrite & clk_en;
    assign acc_r    = psel & penable & ~pwrite & clk_en;
    assign is_word  = (paddr[11:`RXSC_AREA_LSB] == 5'(`RXSC_OFF_CTRL >> `RXSC_AREA_LSB))
                    && (paddr[1:0] == 2'h0);
    assign word_idx = paddr[6:2];
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;

    // broadcast invalid makes address 31 commands not valid at all
    assign bc_cmd  = (cmd_rt_addr == `RXSC_BROADCAST_SEEN_FLAG_ADDR);
    assign sel_now = cmd_valid & ~cmd_tr
                   & (cmd_subaddr >= `RXSC_SA_MIN) & (cmd_subaddr <= `RXSC_SA_MAX)
                   & ~(bc_cmd & broadcast_invalid_cfg);
    assign sel_valid = sel_now;
    assign cur_word  = word_reg[cur_sa_reg];
    assign subaddr_busy_force   = act_reg & cur_word[`RXSC_BIT_BUSY];
    assign store_enable         = act_reg & ~cur_word[`RXSC_BIT_BUSY];
    assign pingpong_select_flag = cur_word[`RXSC_BIT_PP];
    assign fin = act_reg & msg_done & terminal_execute_en;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg  <= rxsc_pkg::RXSC_ST_IDLE;
            act_reg    <= 1'b0;
            cur_sa_reg <= 5'h00;
            cur_bc_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sel_now && terminal_execute_en)
            begin
                act_reg    <= 1'b1;
                cur_sa_reg <= cmd_subaddr;
                cur_bc_reg <= bc_cmd;
                state_reg  <= rxsc_pkg::RXSC_ST_IDLE;
            end
            else if (fin)
            begin
                act_reg   <= 1'b0;
                state_reg <= rxsc_pkg::RXSC_ST_DONE;
            end
            else
            begin
                case (state_reg)
                    rxsc_pkg::RXSC_ST_DONE: state_reg <= rxsc_pkg::RXSC_ST_IDLE;
                    default:                state_reg <= rxsc_pkg::RXSC_ST_IDLE;
                endcase
            end
        end
    end

    // interrupt needs both the word bit and the global enable
    always_comb
    begin
        irq_evt = 3'h0;
        if (fin)
        begin
            irq_evt[`RXSC_IRQ_IXZ] = cur_word[`RXSC_BIT_INDEX_ZERO_IRQ_EN] & gie_reg[`RXSC_IRQ_IXZ]
                                   & (index_zero_evt | circ_count_evt);
            irq_evt[`RXSC_IRQ_IWA] = cur_word[`RXSC_BIT_IWA] & gie_reg[`RXSC_IRQ_IWA];
            irq_evt[`RXSC_IRQ_IBR] = cur_word[`RXSC_BIT_IBR] & gie_reg[`RXSC_IRQ_IBR]
                                   & cur_bc_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `RXSC_NUM_SA; gi = gi + 1)
        begin : g_word
            logic hit_w;
            logic hit_r;
            logic own;
            logic [15:0] wmask;
            assign hit_w = acc_w & is_word & (word_idx == 5'(gi));
            assign hit_r = acc_r & is_word & (word_idx == 5'(gi));
            assign own   = fin & (cur_sa_reg == 5'(gi));
            // 8-11 never host writable; 0-2,4-7 only while halted
            assign wmask = terminal_execute_en ? `RXSC_HOST_ANY_MASK
                         : (`RXSC_HOST_ANY_MASK | `RXSC_HOST_IDLE_MASK);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    word_reg[gi] <= `RXSC_WORD_RESET;
                else if (clk_en)
                begin
                    if (soft_reset)
                    begin
                        word_reg[gi] <= word_reg[gi] & ~`RXSC_SR_CLR_MASK;
                        // same-cycle completion still marks the word; set wins
                        if (own)
                        begin
                            word_reg[gi][`RXSC_BIT_ACC] <= 1'b1;
                            if (cur_bc_reg)
                                word_reg[gi][`RXSC_BIT_BC] <= 1'b1;
                        end
                    end
                    else
                    begin
                        if (hit_w)
                            word_reg[gi] <= (word_reg[gi] & ~wmask)
                                          | (pwdata[15:0] & wmask);
                        // read clears accessed; a same-cycle completion wins
                        if (hit_r)
                            word_reg[gi][`RXSC_BIT_ACC] <= 1'b0;
                        if (own)
                        begin
                            word_reg[gi][`RXSC_BIT_ACC] <= 1'b1;
                            if (cur_bc_reg)
                                word_reg[gi][`RXSC_BIT_BC] <= 1'b1;
                            if (cfg_reg[`RXSC_CFG_PPMODE] && !msg_error
                                && !word_reg[gi][`RXSC_BIT_BUSY])
                                word_reg[gi][`RXSC_BIT_PP] <= ~word_reg[gi][`RXSC_BIT_PP];
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg  <= 3'h0;
            gie_reg  <= 3'h0;
            mask_reg <= 3'h0;
        end
        else if (clk_en && acc_w)
        begin
            if (paddr == `RXSC_OFF_CFG)
                cfg_reg <= pwdata[2:0];
            if (paddr == `RXSC_OFF_GIE)
                gie_reg <= pwdata[2:0];
            if (paddr == `RXSC_OFF_MASK)
                mask_reg <= pwdata[2:0];
        end
    end

    // read clears status; new events in the same cycle still land
    always_comb
    begin
        stat_next = stat_reg;
        if (acc_r && paddr == `RXSC_OFF_STAT)
            stat_next = 3'h0;
        stat_next = stat_next | irq_evt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_reg <= 3'h0;
        else if (clk_en)
            stat_reg <= stat_next;
    end

    // log keeps only the latest entry: word index and cause bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            log_reg <= 16'h0000;
        else if (clk_en && irq_evt != 3'h0)
            log_reg <= {5'h00, cur_sa_reg, 3'h0, irq_evt};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            message_irq_out <= 1'b0;
        else if (clk_en)
            message_irq_out <= |(stat_next & mask_reg);
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (is_word)
            prdata = {16'h0000, word_reg[word_idx]};
        else if (paddr == `RXSC_OFF_CFG)
            prdata = {29'h0, cfg_reg};
        else if (paddr == `RXSC_OFF_GIE)
            prdata = {29'h0, gie_reg};
        else if (paddr == `RXSC_OFF_STAT)
            prdata = {29'h0, stat_reg};
        else if (paddr == `RXSC_OFF_MASK)
            prdata = {29'h0, mask_reg};
        else if (paddr == `RXSC_OFF_LOG)
            prdata = {16'h0000, log_reg};
    end

    AST_BLOCKED_BITS: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && acc_w && is_word && !act_reg && !soft_reset && !fin)
        |=> word_reg[$past(word_idx)][11:8] == $past(word_reg[word_idx][11:8]))
        else $error("host write changed device bits");

    AST_READ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && acc_r && is_word && !fin)
        |=> !word_reg[$past(word_idx)][`RXSC_BIT_ACC])
        else $error("accessed flag not cleared by read");

    AST_ACC_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fin)
        |=> word_reg[$past(cur_sa_reg)][`RXSC_BIT_ACC])
        else $error("accessed flag not set");

    AST_IRQ_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && (irq_evt & mask_reg) != 3'h0)
        |=> message_irq_out)
        else $error("interrupt output missing");

    AST_NO_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_tr || cmd_subaddr == 5'h00 || cmd_subaddr == 5'h1F)
        |-> !sel_valid)
        else $error("bad command selected");

    AST_BC_INV: assert property (@(posedge pclk) disable iff (!presetn)
        (broadcast_invalid_cfg && cmd_rt_addr == 5'h1F)
        |-> !sel_valid)
        else $error("broadcast accepted while invalid");

    AST_SR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && soft_reset && !fin) |=> (word_reg[$past(cur_sa_reg)][11:9] == 3'h0)
        && (word_reg[$past(cur_sa_reg)][15:12] == $past(word_reg[cur_sa_reg][15:12])))
        else $error("soft reset handled wrong");

    AST_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        (gie_reg == 3'h0)
        |-> (irq_evt == 3'h0))
        else $error("interrupt without global enable");

    AST_IDLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_w && is_word && !terminal_execute_en && !soft_reset)
        |=> (word_reg[$past(word_idx)] & `RXSC_HOST_IDLE_MASK)
            == ($past(pwdata[15:0]) & `RXSC_HOST_IDLE_MASK))
        else $error("idle write not taken");

    AST_RUN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_w && is_word && terminal_execute_en && !soft_reset)
        |=> (word_reg[$past(word_idx)] & `RXSC_HOST_IDLE_MASK)
            == $past(word_reg[word_idx] & `RXSC_HOST_IDLE_MASK))
        else $error("protected bits written while running");

    AST_ANY_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_w && is_word && !soft_reset)
        |=> (word_reg[$past(word_idx)] & `RXSC_HOST_ANY_MASK)
            == ($past(pwdata[15:0]) & `RXSC_HOST_ANY_MASK))
        else $error("always writable bits not taken");

    AST_NO_RUN_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !terminal_execute_en && !acc_w && !acc_r && !soft_reset)
        |=> word_reg[$past(cur_sa_reg)][11:8] == $past(word_reg[cur_sa_reg][11:8]))
        else $error("device bits changed while halted");

    AST_SEL_OK: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_valid && !cmd_tr && cmd_subaddr >= `RXSC_SA_MIN
         && cmd_subaddr <= `RXSC_SA_MAX && cmd_rt_addr != `RXSC_BROADCAST_SEEN_FLAG_ADDR)
        |-> sel_valid)
        else $error("good command not selected");

    AST_IRQ_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && (stat_reg & mask_reg) != 3'h0 && !(acc_r && paddr == `RXSC_OFF_STAT))
        |=> message_irq_out)
        else $error("interrupt output dropped");

    AST_STAT_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !(acc_r && paddr == `RXSC_OFF_STAT))
        |=> (stat_reg & $past(stat_reg)) == $past(stat_reg))
        else $error("status bit lost");

    AST_STAT_RDCLR: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_r && paddr == `RXSC_OFF_STAT && irq_evt == 3'h0)
        |=> stat_reg == 3'h0)
        else $error("status not cleared by read");

    AST_LOG: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && irq_evt != 3'h0)
        |=> (log_reg[2:0] == $past(irq_evt)) && (log_reg[10:6] == $past(cur_sa_reg)))
        else $error("interrupt not logged");

    AST_PP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fin && !soft_reset
         && (msg_error || !cfg_reg[`RXSC_CFG_PPMODE] || cur_word[`RXSC_BIT_BUSY]))
        |=> word_reg[$past(cur_sa_reg)][`RXSC_BIT_PP] == $past(cur_word[`RXSC_BIT_PP]))
        else $error("select flag toggled wrongly");

    AST_PP_FLIP: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fin && !soft_reset
         && !msg_error && cfg_reg[`RXSC_CFG_PPMODE] && !cur_word[`RXSC_BIT_BUSY])
        |=> word_reg[$past(cur_sa_reg)][`RXSC_BIT_PP] != $past(cur_word[`RXSC_BIT_PP]))
        else $error("select flag not toggled");

    AST_BC_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fin && cur_bc_reg)
        |=> word_reg[$past(cur_sa_reg)][`RXSC_BIT_BC])
        else $error("broadcast flag not set");

    AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
        (!clk_en)
        |=> $stable(stat_reg) && $stable(cfg_reg) && $stable(act_reg) && $stable(message_irq_out))
        else $error("state moved while clock enable low");
endmodule : rxsc_ctrl_word

// [rxsc_cfg.svh]
`ifndef RXSC_CFG_SVH
`define RXSC_CFG_SVH
`define RXSC_NUM_SA        32
`define RXSC_SA_MIN        5'h01
`define RXSC_SA_MAX        5'h1E
`define RXSC_BROADCAST_SEEN_FLAG_ADDR    5'h1F
`define RXSC_OFF_CTRL      12'h000
`define RXSC_AREA_LSB      7
`define RXSC_OFF_CFG       12'h080
`define RXSC_OFF_GIE       12'h084
`define RXSC_OFF_STAT      12'h088
`define RXSC_OFF_MASK      12'h08C
`define RXSC_OFF_LOG       12'h090
`define RXSC_WORD_RESET    16'h0000
`define RXSC_HOST_IDLE_MASK 16'h00F7
`define RXSC_HOST_ANY_MASK  16'hF008
`define RXSC_SR_CLR_MASK   16'h0E00
`define RXSC_BIT_INDEX_ZERO_IRQ_EN     15
`define RXSC_BIT_IWA       14
`define RXSC_BIT_IBR       13
`define RXSC_BIT_BUSY      12
`define RXSC_BIT_ACC       11
`define RXSC_BIT_PP        10
`define RXSC_BIT_BC        9
`define RXSC_CFG_TERMINAL_EXECUTE_EN      0
`define RXSC_CFG_BCINV     1
`define RXSC_CFG_PPMODE    2
`define RXSC_IRQ_IXZ       0
`define RXSC_IRQ_IWA       1
`define RXSC_IRQ_IBR       2
`endif

// [rxsc_pkg.sv]
package rxsc_pkg;
    typedef enum logic [1:0]
    {
        RXSC_BUF_INDEXED = 2'h0,
        RXSC_BUF_PINGPONG = 2'h1,
        RXSC_BUF_CIRC1 = 2'h2,
        RXSC_BUF_CIRC2 = 2'h3
    } rxsc_buf_mode_e;
    typedef enum logic [0:0]
    {
        RXSC_ST_IDLE = 1'h0,
        RXSC_ST_DONE = 1'h1
    } rxsc_state_e;
endpackage : rxsc_pkg

// [rxsc_msg_engine.sv]
`timescale 1ns/1ps
module rxsc_msg_engine
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] req,
    output logic             cmd_valid,
    output logic             cmd_tr,
    output logic [4:0]       cmd_rt_addr,
    output logic [4:0]       cmd_subaddr,
    output logic             msg_done,
    output logic             msg_error,
    output logic             index_zero_evt,
    output logic             circ_count_evt
);
    // idle command fields flip each cycle so no stale value looks valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {cmd_valid, cmd_tr, cmd_rt_addr, cmd_subaddr} <= 12'h000;
        else if (req[15])
            {cmd_valid, cmd_tr, cmd_rt_addr, cmd_subaddr} <= req[15:4];
        else
            {cmd_valid, cmd_tr, cmd_rt_addr, cmd_subaddr} <= {1'b0, ~cmd_tr, ~cmd_rt_addr,
                                                              ~cmd_subaddr};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {msg_done, msg_error, index_zero_evt, circ_count_evt} <= 4'h0;
        else
            {msg_done, msg_error, index_zero_evt, circ_count_evt} <= req[3:0];
    end
endmodule : rxsc_msg_engine

// [rx_subaddress_control_word_tb.sv]
`timescale 1ns/1ps
`include "rxsc_cfg.svh"
module rx_subaddress_control_word_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, soft_reset, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] req, wm;
    logic        cmd_valid, cmd_tr, msg_done, msg_error, index_zero_evt, circ_count_evt;
    logic [4:0]  cmd_rt_addr, cmd_subaddr;
    logic        sel_valid, subaddr_busy_force, store_enable, pingpong_select_flag;
    logic        message_irq_out;
    logic [7:0]  r, r2;
    int          n_errors;
    int          cmp_count;
    localparam logic [11:0] W5 = `RXSC_OFF_CTRL + 12'h014;

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    rxsc_ctrl_word dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .soft_reset, .cmd_valid, .cmd_tr, .cmd_rt_addr,
        .cmd_subaddr, .msg_done, .msg_error, .index_zero_evt, .circ_count_evt, .sel_valid,
        .subaddr_busy_force, .store_enable, .pingpong_select_flag, .message_irq_out);
    rxsc_msg_engine eng_u (.pclk, .presetn, .req, .cmd_valid, .cmd_tr, .cmd_rt_addr,
        .cmd_subaddr, .msg_done, .msg_error, .index_zero_evt, .circ_count_evt);

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // host write merge: idle leaves only 8..11, running leaves 0..2 and 4..11
    function automatic logic [15:0] hw(input logic [15:0] o, input logic [15:0] d, input logic x);
        logic [15:0] m;
        m = x ? 16'hF008 : 16'hF0FF;
        return (o & ~m) | (d & m);
    endfunction : hw
    function automatic logic es(input logic [15:0] c, input logic bi);
        return c[15] && !c[14] && c[8:4] >= 5'h01 && c[8:4] <= 5'h1E && !(c[13:9] == 5'h1F && bi);
    endfunction : es
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        tick(1);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        k = 0;
        do
        begin
            tick(1);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask : apb
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, q);
    endtask : rd
    task automatic msg(input logic [4:0] rt, input logic [4:0] sa, input logic z, input logic dn,
                       input logic bz);
        tick(1);
        req <= {2'b10, rt, sa, 4'h0};
        tick(3);
        #1;
        chk("busy", 32'(bz), 32'(subaddr_busy_force));
        chk("store", 32'(!bz), 32'(store_enable));
        tick(1);
        // z picks the index-zero event, otherwise the circular count event
        if (dn)
            req <= {2'b10, rt, sa, 2'b10, z, ~z};
        tick(1);
        req <= 16'h0000;
        tick(3);
        #1;
    endtask : msg

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, soft_reset, req} = '0;
        clk_en = 1'b1;
        n_errors = 0;
        cmp_count = 0;
        r = 8'h23;
        tick(16);
        presetn <= 1'b1;
        rd("word", W5, 32'h0000_0000);
        wm = hw(16'h0000, 16'hFFFF, 1'b0);
        apb(1'b1, W5, 32'h0000_FFFF);
        rd("word", W5, 32'(wm));
        apb(1'b1, `RXSC_OFF_CFG, 32'h0000_0001);
        wm = hw(wm, 16'h0000, 1'b1);
        apb(1'b1, W5, 32'h0000_0000);
        rd("word", W5, 32'(wm));
        wm = hw(wm, 16'hC000, 1'b1);
        apb(1'b1, W5, 32'(wm));
        apb(1'b1, `RXSC_OFF_GIE, 32'h0000_0001);
        apb(1'b1, `RXSC_OFF_MASK, 32'h0000_0000);
        msg(5'h05, 5'h05, 1'b1, 1'b1, 1'b0);
        chk("irq", 32'h0, 32'(message_irq_out));
        apb(1'b1, `RXSC_OFF_MASK, 32'h0000_0007);
        tick(2);
        #1;
        chk("irq", 32'h1, 32'(message_irq_out));
        rd("stat", `RXSC_OFF_STAT, 32'h0000_0001);
        tick(2);
        #1;
        chk("irq", 32'h0, 32'(message_irq_out));
        rd("word", W5, 32'(wm | 16'h0800));
        rd("word", W5, 32'(wm));
        wm = hw(wm, 16'h1000, 1'b1);
        apb(1'b1, W5, 32'(wm));
        apb(1'b1, `RXSC_OFF_GIE, 32'h0000_0007);
        msg(5'h05, 5'h05, 1'b0, 1'b0, 1'b1);
        wm = hw(wm, 16'h6000, 1'b1);
        apb(1'b1, W5, 32'(wm));
        msg(5'h1F, 5'h05, 1'b0, 1'b1, 1'b0);
        rd("stat", `RXSC_OFF_STAT, 32'h0000_0006);
        rd("log", `RXSC_OFF_LOG, 32'h0000_0146);
        // frozen cycle: soft reset must not land
        clk_en <= 1'b0;
        soft_reset <= 1'b1;
        tick(1);
        clk_en <= 1'b1;
        soft_reset <= 1'b0;
        rd("word", W5, 32'(wm | 16'h0A00));
        soft_reset <= 1'b1;
        tick(1);
        soft_reset <= 1'b0;
        rd("word", W5, 32'(wm));
        wm = hw(wm, 16'hE000, 1'b1);
        apb(1'b1, W5, 32'(wm));
        apb(1'b1, `RXSC_OFF_CFG, 32'h0000_0005);
        msg(5'h05, 5'h05, 1'b0, 1'b1, 1'b0);
        chk("pp", 32'h1, 32'(pingpong_select_flag));
        rd("stat", `RXSC_OFF_STAT, 32'h0000_0003);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        rd("word", W5, 32'h0000_0000);
        rd("none", 12'h0A0, 32'h0000_0000);
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, `RXSC_OFF_CFG, {30'h0, j[0], 1'b1});
            repeat (40)
            begin
                r = lfsr(r);
                r2 = lfsr(r);
                // address 31 forced half the time to reach the broadcast corner
                req <= {r[7:6], r[5:1] | {5{r[0]}}, r2[4:0], 4'h0};
                r = r2;
                tick(2);
                #1;
                chk("sel", 32'(es(req, j[0])), 32'(sel_valid));
                tick(1);
            end
        end
        tally_and_finish();
    end
endmodule : rx_subaddress_control_word_tb
